/* rtl/mmwd_map.vh */
`ifndef MMWD_MAP_VH
`define MMWD_MAP_VH
// ----------------------------------------
// Memory map, word addresses (22 bits)
// ----------------------------------------
`define MMWD_A_VEC_END   22'h000040
`define MMWD_A_SRAM1     22'h000400
`define MMWD_A_PF0       22'h000800
`define MMWD_A_IRQVEC    22'h000D00
`define MMWD_A_PF0B      22'h000E00
`define MMWD_A_ACCREG    22'h001400
`define MMWD_A_MSG_A2C   22'h001480
`define MMWD_A_MSG_C2A   22'h001500
`define MMWD_A_PF0C      22'h001580
`define MMWD_A_PF0_END   22'h002000
`define MMWD_A_PF1       22'h006000
`define MMWD_A_PF3       22'h006400
`define MMWD_A_PF1B      22'h006A00
`define MMWD_A_PF2       22'h007000
`define MMWD_A_LRA       22'h008000
`define MMWD_A_LRB       22'h008800
`define MMWD_A_LRC       22'h008C00
`define MMWD_A_LR_END    22'h009000
`define MMWD_A_OTP       22'h3D7800
`define MMWD_A_OTP_END   22'h3D8000
`define MMWD_A_FL_C      22'h3F4000
`define MMWD_A_FL_B      22'h3F6000
`define MMWD_A_FL_A      22'h3F7000
`define MMWD_A_PWD       22'h3F7FF8
`define MMWD_A_ROM1      22'h3F8000
`define MMWD_A_ROM2      22'h3F8400
`define MMWD_A_ROM_END   22'h3F8800
`define MMWD_A_BOOT      22'h3FD000
// Write-protected windows inside frame zero
`define MMWD_A_WP0       22'h000880
`define MMWD_A_WP0_END   22'h000988
`define MMWD_A_WP1       22'h000A80
`define MMWD_A_WP1_END   22'h000AE0
`define MMWD_A_WP2       22'h000B80
`define MMWD_A_WP2_END   22'h000BF0
// ----------------------------------------
// Region codes
// ----------------------------------------
`define MMWD_RG_NONE     5'h00
`define MMWD_RG_SRAM0    5'h01
`define MMWD_RG_SRAM1    5'h02
`define MMWD_RG_PF0      5'h03
`define MMWD_RG_IRQVEC   5'h04
`define MMWD_RG_ACCREG   5'h05
`define MMWD_RG_MSG_A2C  5'h06
`define MMWD_RG_MSG_C2A  5'h07
`define MMWD_RG_PF1      5'h08
`define MMWD_RG_PF2      5'h09
`define MMWD_RG_PF3      5'h0A
`define MMWD_RG_LRA      5'h0B
`define MMWD_RG_LRB      5'h0C
`define MMWD_RG_LRC      5'h0D
`define MMWD_RG_OTP      5'h0E
`define MMWD_RG_FL_C     5'h0F
`define MMWD_RG_FL_B     5'h10
`define MMWD_RG_FL_A     5'h11
`define MMWD_RG_ROM1     5'h12
`define MMWD_RG_ROM2     5'h13
`define MMWD_RG_BOOT     5'h14
// ----------------------------------------
// Configuration registers, byte offsets
// ----------------------------------------
`define MMWD_OFS_CTRL    8'h00
`define MMWD_OFS_WAIT    8'h04
`define MMWD_OFS_STAT    8'h08
`define MMWD_CTRL_RST    5'h1C
`define MMWD_WAIT_RST    12'hFFF
// ----------------------------------------
// Wait and stall counts, cycles
// ----------------------------------------
`define MMWD_W_PF_RD     5'h02
`define MMWD_W_PWD       5'h10
`define MMWD_W_MIN_RND   5'h01
`define MMWD_W_MIN_OTP   5'h01
`define MMWD_W_STALL     5'h01
`endif

/* rtl/mmwd_region_decode.v */
`timescale 1ns/10ps
`include "mmwd_map.vh"
module mmwd_region_decode (
	input  wire [21:0] addr,
	input  wire        progSpace,
	input  wire        vectorMapSelect,
	input  wire        irqExpansionEnable,
	output reg  [4:0]  region,
	output reg         writeProt
);
	// ----------------------------------------
	// Range test
	// ----------------------------------------
	function inRange;
		input [21:0] a;
		input [21:0] lo;
		input [21:0] hi;
		begin
			inRange = (a >= lo) && (a < hi);
		end
	endfunction

	// Region select; frames answer data space only
	always @*
	begin
		region = `MMWD_RG_NONE;
		if (addr < `MMWD_A_VEC_END)
			region = vectorMapSelect ? `MMWD_RG_NONE : `MMWD_RG_SRAM0; // R05
		else if (addr < `MMWD_A_SRAM1)
			region = `MMWD_RG_SRAM0;
		else if (addr < `MMWD_A_PF0)
			region = `MMWD_RG_SRAM1;
		else if (progSpace && inRange(addr, `MMWD_A_PF0, `MMWD_A_LRA))
			region = `MMWD_RG_NONE; // R24
		else if (inRange(addr, `MMWD_A_IRQVEC, `MMWD_A_PF0B))
		begin
			if (vectorMapSelect && irqExpansionEnable) // R04
				region = `MMWD_RG_IRQVEC;
		end
		else if (inRange(addr, `MMWD_A_ACCREG, `MMWD_A_MSG_A2C))
			region = `MMWD_RG_ACCREG;
		else if (inRange(addr, `MMWD_A_MSG_A2C, `MMWD_A_MSG_C2A))
			region = `MMWD_RG_MSG_A2C;
		else if (inRange(addr, `MMWD_A_MSG_C2A, `MMWD_A_PF0C))
			region = `MMWD_RG_MSG_C2A;
		else if (inRange(addr, `MMWD_A_PF0, `MMWD_A_PF0_END))
			region = `MMWD_RG_PF0; // R21
		else if (inRange(addr, `MMWD_A_PF3, `MMWD_A_PF1B))
			region = `MMWD_RG_PF3; // R22
		else if (inRange(addr, `MMWD_A_PF1, `MMWD_A_PF2))
			region = `MMWD_RG_PF1; // R22
		else if (inRange(addr, `MMWD_A_PF2, `MMWD_A_LRA))
			region = `MMWD_RG_PF2; // R22
		else if (inRange(addr, `MMWD_A_LRA, `MMWD_A_LRB))
			region = `MMWD_RG_LRA; // R23
		else if (inRange(addr, `MMWD_A_LRB, `MMWD_A_LRC))
			region = `MMWD_RG_LRB; // R23
		else if (inRange(addr, `MMWD_A_LRC, `MMWD_A_LR_END))
			region = `MMWD_RG_LRC; // R23
		else if (inRange(addr, `MMWD_A_OTP, `MMWD_A_OTP_END))
			region = `MMWD_RG_OTP;
		else if (inRange(addr, `MMWD_A_FL_C, `MMWD_A_FL_B))
			region = `MMWD_RG_FL_C; // R02
		else if (inRange(addr, `MMWD_A_FL_B, `MMWD_A_FL_A))
			region = `MMWD_RG_FL_B; // R02
		else if (inRange(addr, `MMWD_A_FL_A, `MMWD_A_ROM1))
			region = `MMWD_RG_FL_A; // R01
		else if (inRange(addr, `MMWD_A_ROM1, `MMWD_A_ROM2))
			region = `MMWD_RG_ROM1; // R03
		else if (inRange(addr, `MMWD_A_ROM2, `MMWD_A_ROM_END))
			region = `MMWD_RG_ROM2; // R03
		else if (addr >= `MMWD_A_BOOT)
			region = `MMWD_RG_BOOT;
	end

	// Protected windows in frame zero; timers and expansion stay open
	always @*
	begin
		writeProt = !progSpace &&
			(inRange(addr, `MMWD_A_WP0, `MMWD_A_WP0_END) ||
			inRange(addr, `MMWD_A_WP1, `MMWD_A_WP1_END) ||
			inRange(addr, `MMWD_A_WP2, `MMWD_A_WP2_END) ||
			inRange(addr, `MMWD_A_ACCREG, `MMWD_A_MSG_A2C)); // R17
	end
endmodule // mmwd_region_decode

/* rtl/mmwd_decoder.v */
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "mmwd_map.vh"
// Behaviour
// R01: Flash 16K words ends at 0x3F7FFF
// R02: Sectors C 8K, B 4K, A 4K
// R03: Zone ROMs at 0x3F8000 and 0x3F8400
// R04: Vector RAM needs map select and expansion
// R05: Low vector area only when map select 0
// R06: Protected write then read kept in order
// R07: Ordering per frame, on at reset
// R08: Frame one 0/2 waits plus ready
// R09: Back-to-back frame one writes stall once
// R10: Frame two 0/2 waits, ready ignored
// R11: Frame three 0/2 waits plus ready
// R12: RAMs, frame zero, ROMs zero waits
// R13: OTP waits programmed, at least one
// R14: Flash paged/random waits, random at least one
// R15: Password locations always sixteen waits
// R16: Protected writes dropped until unlocked
// R17: Frame zero protected windows listed
// R18: Message RAMs drop wrong-side writes
// R19: Frame zero takes 16 and 32 bit
// R20: Frame buses; accelerator reaches frame three
// R21: Timers and expansion registers unprotected
// R22: Frames one, three, two placement
// R23: Local RAM blocks placement
// R24: Frames answer data space only
// R25: Reserved space: writes dropped, reads zero
module mmwd_decoder (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	input  wire        protectUnlockInstr,
	input  wire        protectRelockInstr,
	input  wire        cpuReq,
	input  wire        cpuWrite,
	input  wire        cpuProg,
	input  wire        cpuWide,
	input  wire        cpuAccel,
	input  wire [21:0] cpuAddr,
	input  wire [31:0] cpuWdata,
	output reg         cpuDone,
	output reg  [31:0] cpuRdata,
	output reg         tgtReq,
	output reg         tgtWrite,
	output reg         tgtWide,
	output reg  [4:0]  tgtRegion,
	output reg  [21:0] tgtAddr,
	output reg  [31:0] tgtWdata,
	input  wire [31:0] tgtRdata,
	input  wire        tgtReady
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	reg        state_r;
	reg [4:0]  cnt_r;
	reg        needRdy_r;
	reg        discard_r;
	reg        doneDly_r;
	reg        prevOrdWr_r;
	reg [21:0] prevAddr_r;
	reg        prevPf1Wr_r;
	reg [18:0] lastPage_r;
	reg        pageValid_r;
	reg        unlocked_r;
	reg [4:0]  ctrl_r;
	reg [11:0] wait_r;
	reg [4:0]  lastRegion_r;
	reg        blocked_r;

	wire [4:0] decRegion;
	wire       decProt;
	wire       vectorMapSelect    = ctrl_r[0];
	wire       irqExpansionEnable = ctrl_r[1];

	// ----------------------------------------
	// Region decode
	// ----------------------------------------
	mmwd_region_decode uDecode (
		.addr               (cpuAddr),
		.progSpace          (cpuProg),
		.vectorMapSelect    (vectorMapSelect),
		.irqExpansionEnable (irqExpansionEnable),
		.region             (decRegion),
		.writeProt          (decProt)
	);

	// Clamp a programmed count to a floor
	function [4:0] atLeast;
		input [3:0] v;
		input [4:0] floor;
		begin
			atLeast = ({1'b0, v} < floor) ? floor : {1'b0, v};
		end
	endfunction

	// Frame ordering enable for a region
	function ordered;
		input [4:0] rg;
		input [4:0] ctl;
		begin
			ordered = (rg == `MMWD_RG_PF1 && ctl[2]) ||
				(rg == `MMWD_RG_PF2 && ctl[3]) ||
				(rg == `MMWD_RG_PF3 && ctl[4]); // R07
		end
	endfunction

	// ----------------------------------------
	// Access classification
	// ----------------------------------------
	wire isFlash = (decRegion == `MMWD_RG_FL_C) || (decRegion == `MMWD_RG_FL_B) ||
		(decRegion == `MMWD_RG_FL_A);
	wire isPwd   = isFlash && (cpuAddr >= `MMWD_A_PWD);
	wire isPf    = (decRegion == `MMWD_RG_PF1) || (decRegion == `MMWD_RG_PF2) ||
		(decRegion == `MMWD_RG_PF3);
	wire isMsg   = (decRegion == `MMWD_RG_MSG_A2C) || (decRegion == `MMWD_RG_MSG_C2A);
	// Accelerator sees frame three and the message RAMs only
	wire [4:0] region = (cpuAccel && decRegion != `MMWD_RG_PF3 && !isMsg) ?
		`MMWD_RG_NONE : decRegion; // R20
	wire paged = pageValid_r && (lastPage_r == cpuAddr[21:3]);
	wire dropWr = cpuWrite && (
		(decProt && !unlocked_r) || // R16
		(!cpuAccel && decRegion == `MMWD_RG_MSG_A2C) || // R18
		(cpuAccel && decRegion == `MMWD_RG_MSG_C2A)); // R18
	wire ordWr   = cpuWrite && ordered(region, ctrl_r);
	wire ordStall = !cpuWrite && prevOrdWr_r && ordered(region, ctrl_r) &&
		(cpuAddr != prevAddr_r); // R06
	wire pf1Stall = cpuWrite && region == `MMWD_RG_PF1 && prevPf1Wr_r && doneDly_r; // R09

	// Wait count for the decoded access
	reg [4:0] waits;
	always @*
	begin
		waits = 5'h00; // R12
		if (isPwd)
			waits = `MMWD_W_PWD; // R15
		else if (isFlash)
			waits = paged ? {1'b0, wait_r[3:0]} :
				atLeast(wait_r[7:4], `MMWD_W_MIN_RND); // R14
		else if (region == `MMWD_RG_OTP)
			waits = atLeast(wait_r[11:8], `MMWD_W_MIN_OTP); // R13
		else if (isPf && !cpuWrite)
			waits = `MMWD_W_PF_RD; // R08 R10 R11
		if (ordStall || pf1Stall)
			waits = waits + `MMWD_W_STALL;
	end

	wire accept = (state_r == ST_IDLE) && cpuReq && !cpuDone;
	wire noTarget = (region == `MMWD_RG_NONE) || dropWr; // R25
	wire finish = (state_r == ST_WAIT) && (cnt_r == 5'h00) &&
		(!needRdy_r || tgtReady);

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// Request is not sampled while done is high, so a request dropped on seeing done is never taken twice
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r     <= ST_IDLE;
			cnt_r       <= 5'h00;
			needRdy_r   <= 1'b0;
			discard_r   <= 1'b0;
			cpuDone     <= 1'b0;
			cpuRdata    <= 32'h00000000;
			tgtReq      <= 1'b0;
			tgtWrite    <= 1'b0;
			tgtWide     <= 1'b0;
			tgtRegion   <= 5'h00;
			tgtAddr     <= 22'h000000;
			tgtWdata    <= 32'h00000000;
			doneDly_r   <= 1'b0;
			prevOrdWr_r <= 1'b0;
			prevAddr_r  <= 22'h000000;
			prevPf1Wr_r <= 1'b0;
			lastPage_r  <= 19'h00000;
			pageValid_r <= 1'b0;
			lastRegion_r <= 5'h00;
			blocked_r   <= 1'b0;
		end
		else
		begin
			tgtReq    <= 1'b0;
			cpuDone   <= 1'b0;
			doneDly_r <= cpuDone;
			case (state_r)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_r   <= ST_WAIT;
						cnt_r     <= waits;
						discard_r <= noTarget;
						// Frame two never stretches on ready
						needRdy_r <= !noTarget && (region == `MMWD_RG_PF1 ||
							region == `MMWD_RG_PF3); // R08 R11 R10
						tgtReq    <= !noTarget;
						tgtWrite  <= cpuWrite;
						// Frame two is the narrow bus; frame zero takes either width
						tgtWide   <= cpuWide && region != `MMWD_RG_PF2; // R19 R20
						tgtRegion <= region;
						tgtAddr   <= cpuAddr;
						tgtWdata  <= cpuWdata;
						prevOrdWr_r <= ordWr && !noTarget;
						prevAddr_r  <= cpuAddr;
						prevPf1Wr_r <= cpuWrite && region == `MMWD_RG_PF1;
						lastRegion_r <= region;
						if (dropWr)
							blocked_r <= 1'b1;
						if (isFlash)
						begin
							lastPage_r  <= cpuAddr[21:3];
							pageValid_r <= 1'b1;
						end
						else
							pageValid_r <= 1'b0;
					end
				end
				ST_WAIT:
				begin
					if (cnt_r != 5'h00)
						cnt_r <= cnt_r - 5'h01;
					else if (finish)
					begin
						state_r  <= ST_IDLE;
						cpuDone  <= 1'b1;
						cpuRdata <= (discard_r || tgtWrite) ? 32'h00000000 : tgtRdata; // R25
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Unlock state follows the unlock and relock instructions
	always @(posedge clk_sys)
	begin
		if (reset)
			unlocked_r <= 1'b0;
		else if (protectRelockInstr)
			unlocked_r <= 1'b0; // R16
		else if (protectUnlockInstr)
			unlocked_r <= 1'b1; // R16
	end

	// ----------------------------------------
	// Configuration bus slave
	// ----------------------------------------
	// Address and data are taken together; simpler and still legal for the bus
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'b00;
			ctrl_r  <= `MMWD_CTRL_RST; // R07
			wait_r  <= `MMWD_WAIT_RST;
		end
		else
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (!awready && !bvalid && awvalid && wvalid)
			begin
				awready <= 1'b1;
				wready  <= 1'b1;
				bvalid  <= 1'b1;
				bresp   <= 2'b00;
				if (awaddr == `MMWD_OFS_CTRL)
				begin
					if (wstrb[0])
						ctrl_r <= wdata[4:0];
				end
				else if (awaddr == `MMWD_OFS_WAIT)
				begin
					if (wstrb[0])
						wait_r[7:0] <= wdata[7:0];
					if (wstrb[1])
						wait_r[11:8] <= wdata[11:8];
				end
				else if (awaddr != `MMWD_OFS_STAT)
					bresp <= 2'b10;
			end
		end
	end

	// Read channel; status shows live sequencer state
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= 2'b00;
		end
		else
		begin
			arready <= 1'b0;
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (!arready && !rvalid && arvalid)
			begin
				arready <= 1'b1;
				rvalid  <= 1'b1;
				rresp   <= 2'b00;
				if (araddr == `MMWD_OFS_CTRL)
					rdata <= {27'h0000000, ctrl_r};
				else if (araddr == `MMWD_OFS_WAIT)
					rdata <= {20'h00000, wait_r};
				else if (araddr == `MMWD_OFS_STAT)
					rdata <= {19'h00000, lastRegion_r, 5'h00, blocked_r, state_r,
						unlocked_r};
				else
				begin
					rdata <= 32'h00000000;
					rresp <= 2'b10;
				end
			end
		end
	end
endmodule // mmwd_decoder

/* bench/mmwd_decoder_monitor.sv */
`timescale 1ns/10ps
// -------------------------
// CPU-side timing and access checks
// -------------------------
module mmwd_decoder_monitor (
	input logic        clk_sys,
	input logic        reset,
	input logic        cpuDone,
	input logic        cpuAccel,
	input logic [31:0] cpuRdata,
	input logic        tgtReq,
	input logic        tgtWrite,
	input logic [4:0]  tgtRegion,
	input logic [21:0] tgtAddr,
	input logic        tgtReady
);
	logic strobed_r;
	logic pendRdy_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Did the access now finishing reach a target at all
	always @(posedge clk_sys)
		if (reset)
			strobed_r <= 1'b0;
		else if (tgtReq)
			strobed_r <= 1'b1;
		else if (cpuDone)
			strobed_r <= 1'b0;
	// Frames whose peripherals may stretch with ready
	always @(posedge clk_sys)
		if (reset)
			pendRdy_r <= 1'b0;
		else if (tgtReq)
			pendRdy_r <= (tgtRegion == 5'h08) || (tgtRegion == 5'h0A);
		else if (cpuDone)
			pendRdy_r <= 1'b0;
	// Two waits, one more if an ordering stall applies
	sequence s_pfRead;
		!cpuDone [*2] ##[1:2] cpuDone;
	endsequence
	sequence s_pwdWait;
		!cpuDone [*8] ##1 !cpuDone [*8] ##1 cpuDone;
	endsequence
	a_done_pulse: assert property (cpuDone |=> !cpuDone)
		else $error("done longer than one cycle");
	a_strobe_pulse: assert property (tgtReq |=> !tgtReq)
		else $error("strobe longer than one cycle");
	a_zero_wait: assert property (tgtReq && (tgtRegion inside {5'h01, 5'h02, 5'h03,
		5'h04, 5'h05, 5'h06, 5'h07, 5'h0B, 5'h0C, 5'h0D, 5'h12, 5'h13, 5'h14}) |=> cpuDone)
		else $error("zero-wait region took waits");
	a_pf2_write: assert property (tgtReq && tgtWrite && tgtRegion == 5'h09 |=> cpuDone)
		else $error("frame two write waited");
	a_pf2_read: assert property (tgtReq && !tgtWrite && tgtRegion == 5'h09 |=> s_pfRead)
		else $error("frame two read wait wrong");
	a_ready_hold: assert property (pendRdy_r && !tgtReady |=> !cpuDone)
		else $error("finished while ready low");
	a_pwd_wait: assert property (tgtReq && tgtAddr >= 22'h3F7FF8 && tgtAddr <= 22'h3F7FFF
		|=> s_pwdWait)
		else $error("password wait not sixteen");
	a_otp_floor: assert property (tgtReq && tgtRegion == 5'h0E |=> !cpuDone)
		else $error("otp finished without wait");
	a_msg_side: assert property (tgtReq && tgtWrite |-> (tgtRegion != 5'h06 || $past(cpuAccel))
		&& (tgtRegion != 5'h07 || !$past(cpuAccel)))
		else $error("message ram written by wrong side");
	a_rsv_write: assert property (tgtReq && tgtWrite |-> tgtRegion != 5'h00)
		else $error("write strobed to reserved space");
	a_rsv_zero: assert property (cpuDone && !strobed_r |-> cpuRdata == 32'h0)
		else $error("unstrobed access returned data");
endmodule // mmwd_decoder_monitor

/* bench/mmwd_target_model.sv */
`timescale 1ns/10ps
// -------------------------
// Peripheral target model
// -------------------------
module mmwd_target_model (
	input  logic        clk_sys,
	input  logic        reset,
	input  logic        tgtReq,
	input  logic        tgtWrite,
	input  logic [21:0] tgtAddr,
	input  logic [31:0] tgtWdata,
	input  logic [3:0]  stallCyc,
	output logic [31:0] tgtRdata,
	output logic        tgtReady
);
	logic [31:0] mem_r [0:15];
	logic [3:0]  cnt_r;
	// Ready drops in the strobe cycle when stallCyc is nonzero, so even zero-wait frame one and three writes see a stretch
	assign tgtReady = tgtReq ? (stallCyc == 4'h0) : (cnt_r == 4'h0);
	assign tgtRdata = mem_r[tgtAddr[3:0]];
	always @(posedge clk_sys)
		if (reset)
			cnt_r <= 4'h0;
		else if (tgtReq)
			cnt_r <= (stallCyc == 4'h0) ? 4'h0 : stallCyc - 4'h1;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	// Only 16 words that alias, so tests read back before reuse
	always @(posedge clk_sys)
		if (tgtReq && tgtWrite)
			mem_r[tgtAddr[3:0]] <= tgtWdata;
endmodule // mmwd_target_model

/* bench/mmwd_decoder_test.sv */
`timescale 1ns/10ps
module mmwd_decoder_test;
	localparam logic [4:0] WR = 5'h01, PG = 5'h02, WD = 5'h04, AX = 5'h08, CK = 5'h10;
	logic clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, protectUnlockInstr, protectRelockInstr, cpuReq, cpuWrite, cpuProg;
	logic cpuWide, cpuAccel, cpuDone, tgtReq, tgtWrite, tgtWide, tgtReady;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, cpuWdata, cpuRdata, tgtWdata, tgtRdata, rd;
	logic [3:0] wstrb, stallCyc;
	logic [1:0] bresp, rresp;
	logic [4:0] tgtRegion;
	logic [21:0] cpuAddr, tgtAddr;
	int cyc = 0, nStb = 0, n_fail = 0, samples_checked = 0;
	bit heldReq = 0;
	logic [21:0] za [10] = '{22'h10, 22'h400, 22'hC00, 22'hCE0, 22'h8000, 22'h8800, 22'h8C00,
		22'h3F8000, 22'h3F8400, 22'h3FD000};
	logic [4:0] zr [10] = '{5'h01, 5'h02, 5'h03, 5'h03, 5'h0B, 5'h0C, 5'h0D, 5'h12, 5'h13, 5'h14};

	mmwd_decoder u_dut (.clk_sys, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .protectUnlockInstr, .protectRelockInstr, .cpuReq, .cpuWrite, .cpuProg, .cpuWide,
		.cpuAccel, .cpuAddr, .cpuWdata, .cpuDone, .cpuRdata, .tgtReq, .tgtWrite, .tgtWide,
		.tgtRegion, .tgtAddr, .tgtWdata, .tgtRdata, .tgtReady);
	mmwd_target_model u_tgt (.clk_sys, .reset, .tgtReq, .tgtWrite, .tgtAddr, .tgtWdata,
		.stallCyc, .tgtRdata, .tgtReady);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Strobe counter and hang guard
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (tgtReq === 1'b1)
			nStb <= nStb + 1;
		if (cyc == 5000)
		begin
			n_fail = n_fail + 1;
			stop_test;
		end
	end

	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask

	task axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		chk("rresp", rresp, er);
	endtask

	// One CPU access; waits counted from the taking edge; hold keeps the next one back-to-back
	task ac(input logic [21:0] a, input logic [4:0] f, input logic [31:0] d, input int w,
		input logic [4:0] rg, input bit hold);
		int n;
		int s0;
		if (!heldReq)
			@(posedge clk_sys);
		s0 = nStb;
		n = 0;
		cpuReq <= 1'b1;
		cpuAddr <= a;
		{cpuAccel, cpuWide, cpuProg, cpuWrite} <= f[3:0];
		cpuWdata <= d;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (cpuDone !== 1'b1);
		heldReq = hold;
		if (!hold)
			cpuReq <= 1'b0;
		chk("waits", n - 3, w);
		chk("strobes", nStb - s0, rg != 5'h00);
		if (rg != 5'h00)
			chk("region", tgtRegion, rg);
		if (f[4])
			chk("rdata", cpuRdata, d);
	endtask

	// -------------------------
	// Main sequence
	// -------------------------
	initial
	begin
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, cpuReq, cpuWrite, cpuProg, cpuWide} = '0;
		{protectUnlockInstr, protectRelockInstr, cpuAccel} = '0;
		{awaddr, araddr, wdata, cpuAddr, cpuWdata, stallCyc} = '0;
		wstrb = 4'hF;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		axr(8'h00, rd, 2'h0);
		chk("ctrl", rd, 32'h1C);
		axr(8'h0C, rd, 2'h2);
		axw(8'h0C, 32'h0, 2'h2);
		axw(8'h04, 32'h321, 2'h0);
		// Zero-wait places, data kept on the writable ones
		for (int i = 0; i < 10; i++)
		begin
			if (i < 7)
				ac(za[i], WR | WD, 32'hC3C30000 + i, 0, zr[i], 0);
			ac(za[i], (i < 7) ? (CK | WD) : WD, 32'hC3C30000 + i, 0, zr[i], 0);
		end
		ac(22'h3F4000, 5'h00, 0, 2, 5'h0F, 0);
		ac(22'h3F4001, 5'h00, 0, 1, 5'h0F, 0);
		ac(22'h3F6000, 5'h00, 0, 2, 5'h10, 0);
		ac(22'h3F7000, 5'h00, 0, 2, 5'h11, 0);
		ac(22'h3F7FF8, 5'h00, 0, 16, 5'h11, 0);
		ac(22'h3F3FFF, CK, 0, 0, 5'h00, 0);
		ac(22'h3F8800, CK, 0, 0, 5'h00, 0);
		ac(22'h3D7800, 5'h00, 0, 3, 5'h0E, 0);
		axw(8'h04, 32'h0, 2'h0);
		ac(22'h3F5000, 5'h00, 0, 1, 5'h0F, 0);
		ac(22'h3D7801, 5'h00, 0, 1, 5'h0E, 0);
		// Vector RAM selection
		ac(22'h000D00, CK, 0, 0, 5'h00, 0);
		axw(8'h00, 32'h1F, 2'h0);
		ac(22'h000D00, 5'h00, 0, 0, 5'h04, 0);
		ac(22'h000010, CK, 0, 0, 5'h00, 0);
		axw(8'h00, 32'h1D, 2'h0);
		ac(22'h000D00, CK, 0, 0, 5'h00, 0);
		axw(8'h00, 32'h1C, 2'h0);
		// Write protection
		ac(22'h000880, WR, 1, 0, 5'h00, 0);
		ac(22'h001400, WR, 1, 0, 5'h00, 0);
		axr(8'h08, rd, 2'h0);
		chk("blocked", rd & 32'h5, 32'h4);
		@(posedge clk_sys) protectUnlockInstr <= 1'b1;
		@(posedge clk_sys) protectUnlockInstr <= 1'b0;
		axr(8'h08, rd, 2'h0);
		chk("unlocked", rd & 32'h1, 32'h1);
		ac(22'h000880, WR, 1, 0, 5'h03, 0);
		ac(22'h000A80, WR, 1, 0, 5'h03, 0);
		ac(22'h001400, WR | WD, 1, 0, 5'h05, 0);
		chk("wide", tgtWide, 1'b1);
		@(posedge clk_sys) protectRelockInstr <= 1'b1;
		@(posedge clk_sys) protectRelockInstr <= 1'b0;
		ac(22'h000B80, WR, 1, 0, 5'h00, 0);
		ac(22'h001480, WR, 2, 0, 5'h00, 0);
		ac(22'h001480, WR | AX, 2, 0, 5'h06, 0);
		ac(22'h001500, WR | AX, 2, 0, 5'h00, 0);
		ac(22'h001500, WR, 2, 0, 5'h07, 0);
		// Frames: placement, space, waits and ready
		ac(22'h006000, WR | PG, 3, 0, 5'h00, 0);
		ac(22'h006A00, 5'h00, 0, 2, 5'h08, 0);
		ac(22'h008000, AX, 0, 0, 5'h00, 0);
		stallCyc <= 4'h4;
		ac(22'h007010, WR | WD, 32'h1234, 0, 5'h09, 0);
		chk("wide", tgtWide, 1'b0);
		ac(22'h007010, CK, 32'h1234, 2, 5'h09, 0);
		ac(22'h006A04, 5'h00, 0, 4, 5'h08, 0);
		stallCyc <= 4'h0;
		ac(22'h006A06, WR, 7, 0, 5'h08, 1);
		ac(22'h006A07, WR, 8, 1, 5'h08, 1);
		ac(22'h006A08, 5'h00, 0, 3, 5'h08, 0);
		stallCyc <= 4'h3;
		ac(22'h006400, WR, 9, 3, 5'h0A, 0);
		stallCyc <= 4'h0;
		ac(22'h006400, CK | AX, 9, 2, 5'h0A, 0);
		axw(8'h00, 32'h0, 2'h0);
		ac(22'h006A06, WR, 7, 0, 5'h08, 1);
		ac(22'h006A0A, 5'h00, 0, 2, 5'h08, 0);
		stop_test;
	end
endmodule // mmwd_decoder_test

bind mmwd_decoder mmwd_decoder_monitor u_mon (.clk_sys, .reset, .cpuDone, .cpuAccel, .cpuRdata,
	.tgtReq, .tgtWrite, .tgtRegion, .tgtAddr, .tgtReady);
